// file: rtl/shift_pkg.sv
// Constants and types for the eight-stage bidirectional shift block
// Summary of operation
// - Two modes, single-bit and double-word, each with its own eight fields.
// - Mode defaults to single-bit when nothing has been configured.
// - In single-bit mode word inputs and word outputs have no effect.
// - Single-bit mode shows eight one-bit outputs, one per bit field.
// - Double-word mode outputs are signed 32-bit two's-complement values.
// - Gate bit set: enable input decides activity; clear: always active.
// - No retention; every bit and word field starts at zero.
// - Double-word forward shift moves words up; field one takes forward input.
// - Single-bit forward edge moves bits up; field one takes forward bit.
// - Single-bit backward edge moves bits down; field eight takes backward bit.
// - Double-word backward edge moves words down; field eight takes backward input.
// - A clock edge with clear input high zeroes all bit and word fields.
package shift_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int FIELD_COUNT = 8;

	// Register offsets
	localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
	localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
	localparam logic [ADDR_W-1:0] WORD_BASE_OFFSET = 8'h20;

	// Control fields
	localparam int CTRL_MODE_POS = 0;
	localparam int CTRL_GATE_POS = 1;
	localparam logic CTRL_MODE_RESET = 1'h0;
	localparam logic CTRL_GATE_RESET = 1'h0;

	// Status fields
	localparam int STATUS_BITS_POS = 0;
	localparam int STATUS_PEND_FWD_POS = 8;
	localparam int STATUS_PEND_BWD_POS = 9;
	localparam int STATUS_ACTIVE_POS = 10;
	localparam int STATUS_MODE_POS = 11;

	localparam logic [DATA_W-1:0] WORD_RESET = 32'h0000_0000;
	localparam logic [FIELD_COUNT-1:0] BITS_RESET = 8'h00;

	typedef enum logic [1:0] {
		MODE_BIT = 2'h1,
		MODE_DWORD = 2'h2
	} shift_mode_t;

	typedef logic signed [DATA_W-1:0] word_t;

	// Value pushed out of the far end by a shift
	typedef struct packed {
		logic backward;
		logic isWord;
		logic [DATA_W-1:0] data;
	} drop_t;

	localparam drop_t DROP_RESET = '{backward: 1'h0, isWord: 1'h0, data: 32'h0000_0000};

endpackage

// file: rtl/two_entry_buffer.sv
// Two-entry skid buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer import shift_pkg::*; #(
	parameter int WIDTH = $bits(drop_t)
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Filling side
	input wire logic inValid,
	input wire logic [WIDTH-1:0] inData,
	output logic inReady,
	// Draining side
	output logic outValid,
	output logic [WIDTH-1:0] outData,
	input wire logic outReady
);

	logic skidValid;
	logic [WIDTH-1:0] skidData;
	logic next_outValid;
	logic [WIDTH-1:0] next_outData;
	logic next_skidValid;
	logic [WIDTH-1:0] next_skidData;
	logic next_inReady;

	// Ready is a flop so the source never sees a combinational path from outReady
	always_comb
	begin
		next_outValid = outValid;
		next_outData = outData;
		next_skidValid = skidValid;
		next_skidData = skidData;
		if (!outValid || outReady)
		begin
			if (skidValid)
			begin
				next_outData = skidData;
				next_outValid = 1'h1;
				next_skidValid = 1'h0;
			end
			else if (inValid && inReady)
			begin
				next_outData = inData;
				next_outValid = 1'h1;
			end
			else
			begin
				next_outValid = 1'h0;
			end
		end
		else if (inValid && inReady)
		begin
			next_skidData = inData;
			next_skidValid = 1'h1;
		end
		next_inReady = !next_skidValid;
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			outValid <= 1'h0;
			outData <= '0;
			skidValid <= 1'h0;
			skidData <= '0;
			inReady <= 1'h1;
		end
		else
		begin
			outValid <= next_outValid;
			outData <= next_outData;
			skidValid <= next_skidValid;
			skidData <= next_skidData;
			inReady <= next_inReady;
		end
	end

endmodule
`default_nettype wire

// file: rtl/bidir_shift_block.sv
// Eight-stage bidirectional shift block with bit and double-word modes
`timescale 1ns/1ps
`default_nettype none
module bidir_shift_block import shift_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [DATA_W-1:0] regRdData,
	// Program inputs
	input wire logic enableIn,
	input wire logic fwdShiftPulse,
	input wire logic bwdShiftPulse,
	input wire logic clearAll,
	input wire logic fwdBitIn,
	input wire logic bwdBitIn,
	input wire logic [DATA_W-1:0] fwdWordIn,
	input wire logic [DATA_W-1:0] bwdWordIn,
	// Field outputs
	output logic [FIELD_COUNT-1:0] bitFieldOutputs,
	output word_t wordFieldOutputs [FIELD_COUNT],
	// Dropped values
	output drop_t dropData,
	output logic dropValid,
	input wire logic dropReady
);

	// Configuration and edge state
	shift_mode_t mode;
	logic gateEnable;
	logic prevFwd;
	logic prevBwd;
	logic pendFwd;
	logic pendBwd;
	shift_mode_t next_mode;
	logic next_gateEnable;
	logic next_pendFwd;
	logic next_pendBwd;

	// Field state
	logic [FIELD_COUNT-1:0] next_bitFields;
	word_t next_wordFields [FIELD_COUNT];
	word_t wordsUp [FIELD_COUNT];
	word_t wordsDown [FIELD_COUNT];

	// Control terms
	logic active;
	logic edgeFwd;
	logic edgeBwd;
	logic wantFwd;
	logic wantBwd;
	logic doFwd;
	logic doBwd;
	logic bufReady;
	logic bufPush;
	drop_t bufData;
	logic [DATA_W-1:0] next_rdData;

	// True when the address hits one of the word field registers
	function automatic logic isWordAddr(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] rel;
		rel = a - WORD_BASE_OFFSET;
		isWordAddr = (a >= WORD_BASE_OFFSET) && (rel[1:0] == 2'h0)
			&& (rel[ADDR_W-1:2] < FIELD_COUNT[ADDR_W-3:0]);
	endfunction

	function automatic logic [2:0] wordIndex(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] rel;
		rel = a - WORD_BASE_OFFSET;
		wordIndex = rel[4:2];
	endfunction

	// Mode decode shared by the drop path and both read paths
	function automatic logic isDword(input shift_mode_t m);
		isDword = (m == MODE_DWORD);
	endfunction

	function automatic logic isCtrlAddr(input logic [ADDR_W-1:0] a);
		isCtrlAddr = (a == CTRL_OFFSET);
	endfunction

	// Neighbour words for both shift directions
	genvar g;
	generate
		for (g = 0; g < FIELD_COUNT; g++)
		begin : gen_shift
			if (g == 0)
			begin : gen_first
				assign wordsUp[g] = word_t'(fwdWordIn);
				assign wordsDown[g] = wordFieldOutputs[g + 1];
			end
			else if (g == FIELD_COUNT - 1)
			begin : gen_last
				assign wordsUp[g] = wordFieldOutputs[g - 1];
				assign wordsDown[g] = word_t'(bwdWordIn);
			end
			else
			begin : gen_mid
				assign wordsUp[g] = wordFieldOutputs[g - 1];
				assign wordsDown[g] = wordFieldOutputs[g + 1];
			end
		end
	endgenerate

	// Activity and edge handling
	always_comb
	begin
		active = !gateEnable || enableIn;
		edgeFwd = fwdShiftPulse && !prevFwd;
		edgeBwd = bwdShiftPulse && !prevBwd;
		wantFwd = active && (edgeFwd || pendFwd);
		// Backward edge lost when a forward edge lands in the same cycle
		wantBwd = active && !wantFwd && (pendBwd || (edgeBwd && !edgeFwd));
		// A full drop buffer holds the shift back as pending; a repeat edge in that direction merges into it
		doFwd = !clearAll && wantFwd && bufReady;
		doBwd = !clearAll && wantBwd && bufReady;
		next_pendFwd = 1'h0;
		next_pendBwd = 1'h0;
		if (!clearAll)
		begin
			// Pending edges survive an inactive spell and wait for the block to wake
			next_pendFwd = (pendFwd || (active && edgeFwd)) && !doFwd;
			next_pendBwd = (pendBwd || (active && edgeBwd && !edgeFwd)) && !doBwd;
		end
	end

	// Field updates
	always_comb
	begin
		next_bitFields = bitFieldOutputs;
		for (int i = 0; i < FIELD_COUNT; i++)
		begin
			next_wordFields[i] = wordFieldOutputs[i];
		end
		if (clearAll)
		begin
			next_bitFields = BITS_RESET;
			for (int i = 0; i < FIELD_COUNT; i++)
			begin
				next_wordFields[i] = WORD_RESET;
			end
		end
		else
		begin
			unique case (mode)
				MODE_BIT:
				begin
					// Word inputs are never read here
					if (doFwd)
					begin
						next_bitFields = {bitFieldOutputs[FIELD_COUNT-2:0], fwdBitIn};
					end
					else if (doBwd)
					begin
						next_bitFields = {bwdBitIn, bitFieldOutputs[FIELD_COUNT-1:1]};
					end
				end
				MODE_DWORD:
				begin
					for (int i = 0; i < FIELD_COUNT; i++)
					begin
						if (doFwd)
						begin
							next_wordFields[i] = wordsUp[i];
						end
						else if (doBwd)
						begin
							next_wordFields[i] = wordsDown[i];
						end
					end
				end
			endcase
		end
	end

	// Dropped value toward the buffer
	always_comb
	begin
		bufPush = doFwd || doBwd;
		bufData = DROP_RESET;
		bufData.backward = doBwd;
		bufData.isWord = isDword(mode);
		unique case (mode)
			MODE_BIT:
			begin
				bufData.data = {31'h0000_0000, doBwd ? bitFieldOutputs[0]
					: bitFieldOutputs[FIELD_COUNT-1]};
			end
			MODE_DWORD:
			begin
				bufData.data = doBwd ? wordFieldOutputs[0] : wordFieldOutputs[FIELD_COUNT-1];
			end
		endcase
	end

	// Register writes
	always_comb
	begin
		next_mode = mode;
		next_gateEnable = gateEnable;
		if (regWrite && isCtrlAddr(regAddr))
		begin
			next_mode = regWrData[CTRL_MODE_POS] ? MODE_DWORD : MODE_BIT;
			next_gateEnable = regWrData[CTRL_GATE_POS];
		end
	end

	// Register reads, zero outside the cycle after a read strobe
	always_comb
	begin
		next_rdData = '0;
		if (regRead)
		begin
			if (isCtrlAddr(regAddr))
			begin
				next_rdData[CTRL_MODE_POS] = isDword(mode);
				next_rdData[CTRL_GATE_POS] = gateEnable;
			end
			else if (regAddr == STATUS_OFFSET)
			begin
				next_rdData[STATUS_BITS_POS +: FIELD_COUNT] = bitFieldOutputs;
				next_rdData[STATUS_PEND_FWD_POS] = pendFwd;
				next_rdData[STATUS_PEND_BWD_POS] = pendBwd;
				next_rdData[STATUS_ACTIVE_POS] = active;
				next_rdData[STATUS_MODE_POS] = isDword(mode);
			end
			else if (isWordAddr(regAddr))
			begin
				next_rdData = wordFieldOutputs[wordIndex(regAddr)];
			end
		end
	end

	// Edge and pending state
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			// Zero matches the idle pulse level, so release brings no false edge
			prevFwd <= 1'h0;
			prevBwd <= 1'h0;
			pendFwd <= 1'h0;
			pendBwd <= 1'h0;
		end
		else
		begin
			prevFwd <= fwdShiftPulse;
			prevBwd <= bwdShiftPulse;
			pendFwd <= next_pendFwd;
			pendBwd <= next_pendBwd;
		end
	end

	// Configuration and read data
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			mode <= MODE_BIT;
			gateEnable <= CTRL_GATE_RESET;
			regRdData <= '0;
		end
		else
		begin
			mode <= next_mode;
			gateEnable <= next_gateEnable;
			regRdData <= next_rdData;
		end
	end

	// Field registers, cleared from reset on since nothing is retained
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			bitFieldOutputs <= BITS_RESET;
			for (int i = 0; i < FIELD_COUNT; i++)
			begin
				wordFieldOutputs[i] <= WORD_RESET;
			end
		end
		else
		begin
			bitFieldOutputs <= next_bitFields;
			for (int i = 0; i < FIELD_COUNT; i++)
			begin
				wordFieldOutputs[i] <= next_wordFields[i];
			end
		end
	end

	two_entry_buffer #(
		.WIDTH($bits(drop_t))
	) dropBuffer (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.inValid(bufPush),
		.inData(bufData),
		.inReady(bufReady),
		.outValid(dropValid),
		.outData(dropData),
		.outReady(dropReady)
	);

endmodule
`default_nettype wire

// file: verification/shift_props.sv
// Checker for the bidirectional shift block ports
`timescale 1ns/1ps
`default_nettype none
module shift_props import shift_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Watched ports
	input wire logic clearAll,
	input wire logic dropReady,
	input wire logic dropValid,
	input wire drop_t dropData,
	input wire logic [FIELD_COUNT-1:0] bitFieldOutputs,
	input wire word_t wordFieldOutputs [FIELD_COUNT]
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	property p_clear;
		clearAll |=> bitFieldOutputs == 8'h00 && wordFieldOutputs[7] == 32'h0;
	endproperty
	a_clear: assert property (p_clear) else $error("fields not cleared");
	property p_rst;
		$fell(sys_rst) |-> bitFieldOutputs == 8'h00 && wordFieldOutputs[3] == 32'h0 && !dropValid;
	endproperty
	a_rst: assert property (p_rst) else $error("fields not zero after reset");
	property p_push;
		$changed(bitFieldOutputs) && !$past(clearAll) |-> dropValid;
	endproperty
	a_push: assert property (p_push) else $error("shift without drop");
	property p_bitShape;
		$changed(bitFieldOutputs) && !$past(clearAll) |->
			bitFieldOutputs[7:1] == $past(bitFieldOutputs[6:0]) ||
			bitFieldOutputs[6:0] == $past(bitFieldOutputs[7:1]);
	endproperty
	a_bitShape: assert property (p_bitShape) else $error("bit move wrong");
	property p_wordShape;
		$changed(wordFieldOutputs[0]) && !$past(clearAll) |->
			wordFieldOutputs[1] == $past(wordFieldOutputs[0]) ||
			wordFieldOutputs[0] == $past(wordFieldOutputs[1]);
	endproperty
	a_wordShape: assert property (p_wordShape) else $error("word move wrong");
	property p_ownSet;
		$changed(bitFieldOutputs) && !$past(clearAll) |->
			$stable(wordFieldOutputs[0]) && $stable(wordFieldOutputs[7]);
	endproperty
	a_ownSet: assert property (p_ownSet) else $error("bit shift moved words");
	property p_dropHold;
		dropValid && !dropReady |=> dropValid && $stable(dropData);
	endproperty
	a_dropHold: assert property (p_dropHold) else $error("drop lost in stall");
	property p_dropPop;
		$fell(dropValid) |-> $past(dropReady);
	endproperty
	a_dropPop: assert property (p_dropPop) else $error("drop vanished");
endmodule
bind bidir_shift_block shift_props u_props (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .clearAll(clearAll), .dropReady(dropReady),
	.dropValid(dropValid), .dropData(dropData), .bitFieldOutputs(bitFieldOutputs),
	.wordFieldOutputs(wordFieldOutputs));
`default_nettype wire

// file: verification/drop_sink.sv
// Consumer of dropped values, able to stall
`timescale 1ns/1ps
`default_nettype none
module drop_sink import shift_pkg::*; (
	// Clock
	input wire logic sys_clk,
	// Drop stream
	input wire logic dropValid,
	output logic dropReady,
	// Control and count
	input wire logic stall,
	output int popCount
);
	// Ready follows stall only, so a held word is never taken twice
	assign dropReady = !stall;
	initial popCount = 0;
	always @(posedge sys_clk)
		if (dropValid && dropReady)
			popCount <= popCount + 1;
endmodule
`default_nettype wire

// file: verification/bidir_shift_block_bench.sv
// Self-checking bench for the bidirectional shift block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin nMismatch++; \
	$display("mismatch t=%0t got=%0h exp=%0h", $time, a, b); end end
module bidir_shift_block_bench import shift_pkg::*;;
	logic sys_clk = 0, sys_rst = 1, regWrite = 0, regRead = 0, enableIn = 0;
	logic fwdShiftPulse = 0, bwdShiftPulse = 0, clearAll = 0, fwdBitIn = 0, bwdBitIn = 0;
	logic [ADDR_W-1:0] regAddr = 8'h00;
	logic [DATA_W-1:0] regWrData = 32'h0, fwdWordIn = 32'h0, bwdWordIn = 32'h0, rdv;
	logic [DATA_W-1:0] regRdData;
	logic [FIELD_COUNT-1:0] bitFieldOutputs;
	word_t wordFieldOutputs [FIELD_COUNT];
	drop_t dropData;
	logic dropValid, dropReady, stall = 0;
	int popCount, p0, nMismatch = 0, checks = 0;
	bidir_shift_block u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.enableIn(enableIn), .fwdShiftPulse(fwdShiftPulse), .bwdShiftPulse(bwdShiftPulse),
		.clearAll(clearAll), .fwdBitIn(fwdBitIn), .bwdBitIn(bwdBitIn), .fwdWordIn(fwdWordIn),
		.bwdWordIn(bwdWordIn), .bitFieldOutputs(bitFieldOutputs),
		.wordFieldOutputs(wordFieldOutputs), .dropData(dropData), .dropValid(dropValid),
		.dropReady(dropReady));
	drop_sink u_sink (.sys_clk(sys_clk), .dropValid(dropValid), .dropReady(dropReady),
		.stall(stall), .popCount(popCount));
	initial
	begin
		forever #2 sys_clk = ~sys_clk;
	end
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk) {regWrite, regAddr, regWrData} <= {1'b1, a, d};
		@(posedge sys_clk) regWrite <= 0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge sys_clk) {regRead, regAddr} <= {1'b1, a};
		@(posedge sys_clk) regRead <= 0;
		#1 rdv = regRdData;
	endtask
	// Pulse low for at least three cycles between edges keeps every edge distinct
	task shift(input logic f, input logic b);
		@(posedge sys_clk) {fwdShiftPulse, bwdShiftPulse} <= {f, b};
		@(posedge sys_clk) {fwdShiftPulse, bwdShiftPulse} <= 2'b00;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	task t_reset;
		`CHK(bitFieldOutputs, 8'h00)
		`CHK(wordFieldOutputs[7], 32'h0)
		`CHK(dropValid, 1'b0)
		rd(CTRL_OFFSET);
		`CHK(rdv, 32'h0)
		rd(STATUS_OFFSET);
		`CHK(rdv, 32'h0000_0400)
	endtask
	task t_bits;
		@(posedge sys_clk) fwdWordIn <= 32'h1234_5678;
		fwdBitIn <= 1;
		shift(1, 0);
		@(posedge sys_clk) fwdBitIn <= 0;
		shift(1, 0);
		@(posedge sys_clk) fwdBitIn <= 1;
		shift(1, 0);
		`CHK(bitFieldOutputs, 8'h05)
		`CHK(wordFieldOutputs[0], 32'h0)
		@(posedge sys_clk) bwdBitIn <= 1;
		shift(0, 1);
		`CHK(bitFieldOutputs, 8'h82)
		@(posedge sys_clk) fwdBitIn <= 0;
		shift(1, 1);
		`CHK(bitFieldOutputs, 8'h04)
	endtask
	task t_gate;
		wr(CTRL_OFFSET, 32'h2);
		@(posedge sys_clk) fwdBitIn <= 1;
		shift(1, 0);
		`CHK(bitFieldOutputs, 8'h04)
		@(posedge sys_clk) enableIn <= 1;
		shift(1, 0);
		`CHK(bitFieldOutputs, 8'h09)
	endtask
	task t_words;
		wr(CTRL_OFFSET, 32'h1);
		@(posedge sys_clk) fwdWordIn <= 32'h8000_0000;
		shift(1, 0);
		@(posedge sys_clk) fwdWordIn <= 32'h7FFF_FFFF;
		shift(1, 0);
		`CHK(wordFieldOutputs[1], 32'h8000_0000)
		`CHK(wordFieldOutputs[0], 32'h7FFF_FFFF)
		@(posedge sys_clk) bwdWordIn <= 32'hFFFF_FFFF;
		shift(0, 1);
		`CHK(wordFieldOutputs[7], 32'hFFFF_FFFF)
		`CHK(wordFieldOutputs[0], 32'h8000_0000)
		`CHK(bitFieldOutputs, 8'h09)
		rd(WORD_BASE_OFFSET);
		`CHK(rdv, 32'h8000_0000)
		rd(8'h10);
		`CHK(rdv, 32'h0)
	endtask
	task t_stall;
		@(posedge sys_clk) stall <= 1;
		p0 = popCount;
		for (int i = 1; i <= 3; i++)
		begin
			@(posedge sys_clk) fwdWordIn <= i;
			shift(1, 0);
		end
		`CHK(wordFieldOutputs[0], 32'h2)
		`CHK(dropValid, 1'b1)
		`CHK(dropData, {1'b0, 1'b1, 32'hFFFF_FFFF})
		@(posedge sys_clk) stall <= 0;
		repeat (5) @(posedge sys_clk);
		#1;
		`CHK(wordFieldOutputs[0], 32'h3)
		`CHK(wordFieldOutputs[1], 32'h2)
		`CHK(popCount - p0, 3)
	endtask
	task t_clear;
		@(posedge sys_clk) clearAll <= 1;
		@(posedge sys_clk) clearAll <= 0;
		#1;
		`CHK(bitFieldOutputs, 8'h00)
		`CHK(wordFieldOutputs[0], 32'h0)
	endtask
	task closeOut;
		$display("checks=%0d mismatches=%0d", checks, nMismatch);
		if (nMismatch == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(posedge sys_clk);
		sys_rst <= 0;
		@(posedge sys_clk) #1;
		t_reset;
		t_bits;
		t_gate;
		t_words;
		t_stall;
		t_clear;
		closeOut;
	end
	// Whole run needs well under 300 cycles
	initial
	begin
		#20000;
		nMismatch++;
		closeOut;
	end
endmodule
`default_nettype wire
